// ---- src/rtc_divider_chain.sv ----
// real time clock divider chain: source, prescalers, 16-bit and 32-bit timers
//
// What this block does
// - count clock from internal or external pin
// - optional divide-by-32 and divide-by-8 prescalers
// - reloadable 16-bit prescale timer follows prescalers
// - each stage clocks the next stage
// - 32-bit counter of 10,6,6,10-bit sub-timers
// - all stages count up; the prescale timer and each sub-timer can request, the two prescalers cannot
// - all requests merged into one node request
// - only power reset reinitialises the registers
// - prescale timer plus counter form 48-bit timer
// - alarm request when count reaches software value
`timescale 1ns/100ps
`default_nettype none
module rtc_divider_chain (
	input  wire logic                                 core_clk_i,
	input  wire logic                                 reset_i,
	input  wire rtc_chain_pkg::chain_cfg_type         cfg_i,
	input  wire logic                                 int_tick_i,
	input  wire logic                                 ext_clk_i,
	input  wire logic [rtc_chain_pkg::PRESCALE_WIDTH-1:0] prescale_reload_i,
	input  wire logic [rtc_chain_pkg::COUNT_WIDTH-1:0]    sub_reload_i,
	input  wire rtc_chain_pkg::count_write_type       write_i,
	input  wire logic [rtc_chain_pkg::COUNT_WIDTH-1:0]    alarm_value_i,
	input  wire logic                                 alarm_on_i,
	input  wire logic [rtc_chain_pkg::REQ_COUNT-1:0]      req_enable_i,
	output logic [rtc_chain_pkg::PRESCALE_WIDTH-1:0]      prescale_reload_timer_o,
	output logic [rtc_chain_pkg::WORD_WIDTH-1:0]          count_high_word_o,
	output logic [rtc_chain_pkg::WORD_WIDTH-1:0]          count_low_word_o,
	output logic [rtc_chain_pkg::TIMER48_WIDTH-1:0]       timer48_o,
	output logic [rtc_chain_pkg::REQ_COUNT-1:0]           stage_req_o,
	output logic                                          node_req_o
);
	import rtc_chain_pkg::*;

	// reset_i is the power reset; other resets of the chip never reach here
	// so the time base survives them

	logic                       ext_level;
	logic                       ext_prev;
	logic                       next_ext_prev;
	logic                       ext_edge;
	logic                       source_tick;
	logic [4:0]                 div32_cnt;
	logic [4:0]                 next_div32_cnt;
	logic [2:0]                 div8_cnt;
	logic [2:0]                 next_div8_cnt;
	logic                       div32_tick;
	logic                       div8_tick;
	logic [PRESCALE_WIDTH-1:0]  prescale_count;
	logic                       prescale_carry;
	logic [COUNT_WIDTH-1:0]     count;
	logic [COUNT_WIDTH-1:0]     write_image;
	logic [SUB_COUNT:0]         chain_tick;
	logic [SUB_COUNT-1:0]       sub_carry;
	logic [SUB_COUNT-1:0]       sub_load;
	logic                       count_moved;
	logic                       next_count_moved;
	logic                       alarm_hit;
	logic [REQ_COUNT-1:0]       raw_req;
	logic [REQ_COUNT-1:0]       next_req;
	logic                       next_node;

	// the package layout must tile the counter exactly
	localparam int TOP_BIT = SUB_LSB[SUB_COUNT-1] + SUB_W[SUB_COUNT-1];
	if (SUB_LSB[0] != 0) begin : g_bad_base
		$error("lowest sub-timer must start at bit zero");
	end
	for (genvar c = 1; c < SUB_COUNT; c++) begin : g_layout
		if (SUB_LSB[c] != SUB_LSB[c-1] + SUB_W[c-1]) begin : g_gap
			$error("sub-timers must sit side by side");
		end
	end
	if (TOP_BIT != COUNT_WIDTH) begin : g_bad_top
		$error("sub-timers must fill the counter");
	end
	if (SUB_LSB[LOW_WORD_SUBS] != WORD_WIDTH) begin : g_bad_split
		$error("word split must fall on a sub-timer edge");
	end

	// external pin crosses into the core clock before anything reads it
	rtc_sync #(
		.WIDTH (1)
	) u_ext_sync (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    (ext_clk_i),
		.sync_o     (ext_level)
	);

	// source select and prescalers
	always_comb begin
		next_ext_prev = ext_level;
		ext_edge      = ext_level && !ext_prev;
		source_tick   = cfg_i.run &&
			(cfg_i.ext_select ? ext_edge : int_tick_i);

		next_div32_cnt = div32_cnt;
		div32_tick     = source_tick;
		if (cfg_i.div32_on) begin
			div32_tick = source_tick && (div32_cnt == DIV32_LAST);
			if (source_tick) begin
				next_div32_cnt = div32_cnt + 1'b1;
			end
		end else begin
			// a bypassed divider restarts cleanly when switched back in
			next_div32_cnt = DIV32_INIT;
		end

		next_div8_cnt = div8_cnt;
		div8_tick     = div32_tick;
		if (cfg_i.div8_on) begin
			div8_tick = div32_tick && (div8_cnt == DIV8_LAST);
			if (div32_tick) begin
				next_div8_cnt = div8_cnt + 1'b1;
			end
		end else begin
			next_div8_cnt = DIV8_INIT;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ext_prev  <= 1'b0;
			div32_cnt <= DIV32_INIT;
			div8_cnt  <= DIV8_INIT;
		end else begin
			ext_prev  <= next_ext_prev;
			div32_cnt <= next_div32_cnt;
			div8_cnt  <= next_div8_cnt;
		end
	end

	// 16-bit prescale timer
	reload_stage #(
		.WIDTH (PRESCALE_WIDTH)
	) u_prescale (
		.core_clk_i     (core_clk_i),
		.reset_i        (reset_i),
		.tick_i         (div8_tick),
		.load_i         (write_i.wr_prescale),
		.load_value_i   (write_i.prescale),
		.reload_value_i (prescale_reload_i),
		.count_o        (prescale_count),
		.carry_o        (prescale_carry)
	);

	// 32-bit counter as four chained sub-timers
	assign write_image   = {write_i.word, write_i.word};
	assign chain_tick[0] = prescale_carry;

	for (genvar g = 0; g < SUB_COUNT; g++) begin : g_sub
		assign sub_load[g] = (g < LOW_WORD_SUBS) ?
			write_i.wr_low : write_i.wr_high;

		reload_stage #(
			.WIDTH (SUB_W[g])
		) u_sub (
			.core_clk_i     (core_clk_i),
			.reset_i        (reset_i),
			.tick_i         (chain_tick[g]),
			.load_i         (sub_load[g]),
			.load_value_i   (write_image[SUB_LSB[g] +: SUB_W[g]]),
			.reload_value_i (sub_reload_i[SUB_LSB[g] +: SUB_W[g]]),
			.count_o        (count[SUB_LSB[g] +: SUB_W[g]]),
			.carry_o        (sub_carry[g])
		);

		assign chain_tick[g+1] = sub_carry[g];

		chk_carry_source: assert property (
			@(posedge core_clk_i) disable iff (reset_i)
			sub_carry[g] |-> chain_tick[g]
		) else $error("sub-timer carried without an incoming tick");
	end

	assign prescale_reload_timer_o = prescale_count;
	assign count_low_word_o        = count[WORD_WIDTH-1:0];
	assign count_high_word_o       = count[COUNT_WIDTH-1:WORD_WIDTH];
	assign timer48_o               = {count, prescale_count};

	// requests: alarm is checked the cycle after the counter steps so a
	// value written by software alone never raises it
	always_comb begin
		next_count_moved = chain_tick[0];
		alarm_hit = alarm_on_i && count_moved &&
			(count == alarm_value_i);
		raw_req = '0;
		raw_req[REQ_PRESCALE] = prescale_carry;
		for (int i = 0; i < SUB_COUNT; i++) begin
			raw_req[REQ_SUB_BASE + i] = sub_carry[i];
		end
		raw_req[REQ_ALARM] = alarm_hit;
		next_req  = raw_req & req_enable_i;
		next_node = |next_req;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_moved <= 1'b0;
			stage_req_o <= '0;
			node_req_o  <= 1'b0;
		end else begin
			count_moved <= next_count_moved;
			stage_req_o <= next_req;
			node_req_o  <= next_node;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	chk_node_merge: assert property (
		node_req_o == (|stage_req_o)
	) else $error("node request differs from merged stage requests");

	chk_div32_gate: assert property (
		cfg_i.div32_on && div32_tick |-> div32_cnt == DIV32_LAST
	) else $error("divide-by-32 passed a tick early");

	chk_div_bypass: assert property (
		!cfg_i.div32_on && !cfg_i.div8_on |-> div8_tick == source_tick
	) else $error("bypassed prescalers altered the tick");

	chk_ext_select: assert property (
		cfg_i.run && cfg_i.ext_select && ext_edge |-> source_tick
	) else $error("external edge not taken as source");

	chk_chain_carry: assert property (
		prescale_carry && !write_i.wr_low && count[SUB_W[0]-1:0] == '1
		|=> count[SUB_W[0]-1:0] == sub_reload_i[SUB_W[0]-1:0]
	) else $error("prescale overflow did not step the counter");

	chk_alarm_req: assert property (
		alarm_hit && req_enable_i[REQ_ALARM] |=> stage_req_o[REQ_ALARM]
	) else $error("alarm match gave no request");

	chk_req_pulse: assert property (
		prescale_carry && req_enable_i[REQ_PRESCALE]
		|=> stage_req_o[REQ_PRESCALE] && node_req_o
	) else $error("prescale overflow gave no request");

	chk_power_clear: assert property (
		@(posedge core_clk_i) disable iff (1'b0)
		$past(reset_i) |-> timer48_o == '0 && !node_req_o
	) else $error("power reset left state behind");

	chk_timer48_join: assert property (
		timer48_o[PRESCALE_WIDTH-1:0] == prescale_reload_timer_o
	) else $error("48-bit view not joined to prescale timer");

	chk_run_freeze: assert property (
		!cfg_i.run |-> !source_tick
	) else $error("stopped chain took a source tick");

	chk_int_select: assert property (
		cfg_i.run && !cfg_i.ext_select |-> source_tick == int_tick_i
	) else $error("internal tick not taken as source");

	chk_edge_single: assert property (
		ext_edge |=> !ext_edge
	) else $error("one pin edge counted twice");

	chk_div8_gate: assert property (
		cfg_i.div8_on && div8_tick |-> div8_cnt == DIV8_LAST
	) else $error("divide-by-8 passed a tick early");

	chk_div_restart: assert property (
		!cfg_i.div32_on && !cfg_i.div8_on
		|=> div32_cnt == DIV32_INIT && div8_cnt == DIV8_INIT
	) else $error("bypassed prescaler kept its count");

	chk_prescale_step: assert property (
		div8_tick && !prescale_carry && !write_i.wr_prescale
		|=> prescale_count == $past(prescale_count) + 1'b1
	) else $error("prescale timer missed a tick");

	chk_prescale_wrap: assert property (
		prescale_carry && !write_i.wr_prescale
		|=> prescale_count == $past(prescale_reload_i)
	) else $error("prescale timer did not reload on overflow");

	chk_low_load: assert property (
		write_i.wr_low |=> count_low_word_o == $past(write_i.word)
	) else $error("low word write did not land");

	chk_high_load: assert property (
		write_i.wr_high |=> count_high_word_o == $past(write_i.word)
	) else $error("high word write did not land");

	chk_timer48_count: assert property (
		timer48_o[TIMER48_WIDTH-1:PRESCALE_WIDTH] ==
		{count_high_word_o, count_low_word_o}
	) else $error("48-bit view not joined to the counter");

	chk_alarm_quiet: assert property (
		!count_moved |=> !stage_req_o[REQ_ALARM]
	) else $error("alarm raised without a counter step");

	chk_top_request: assert property (
		sub_carry[SUB_COUNT-1] && req_enable_i[REQ_ALARM-1] |=> node_req_o
	) else $error("top sub-timer overflow gave no node request");

	chk_req_masked: assert property (
		!req_enable_i[REQ_PRESCALE] |=> !stage_req_o[REQ_PRESCALE]
	) else $error("disabled prescale request still raised");
endmodule
`default_nettype wire

// ---- src/rtc_chain_pkg.sv ----
// constants and carriers shared by the divider chain files
package rtc_chain_pkg;

	localparam int PRESCALE_WIDTH = 16;
	localparam int COUNT_WIDTH    = 32;
	localparam int WORD_WIDTH     = 16;
	localparam int TIMER48_WIDTH  = PRESCALE_WIDTH + COUNT_WIDTH;
	localparam int SUB_COUNT      = 4;

	// sub-timer layout inside the 32-bit counter, lowest stage first
	localparam int SUB_LSB [SUB_COUNT] = '{0, 10, 16, 22};
	localparam int SUB_W   [SUB_COUNT] = '{10, 6, 6, 10};
	// sub-timers below this index sit in the low word
	localparam int LOW_WORD_SUBS = 2;

	localparam logic [4:0] DIV32_LAST = 5'h1F;
	localparam logic [2:0] DIV8_LAST  = 3'h7;
	localparam logic [4:0] DIV32_INIT = 5'h00;
	localparam logic [2:0] DIV8_INIT  = 3'h0;

	// request vector layout
	localparam int REQ_PRESCALE = 0;
	localparam int REQ_SUB_BASE = 1;
	localparam int REQ_ALARM    = REQ_SUB_BASE + SUB_COUNT;
	localparam int REQ_COUNT    = REQ_ALARM + 1;

	typedef struct packed {
		logic run;
		logic ext_select;
		logic div32_on;
		logic div8_on;
	} chain_cfg_type;

	typedef struct packed {
		logic                   wr_low;
		logic                   wr_high;
		logic [WORD_WIDTH-1:0]  word;
		logic                   wr_prescale;
		logic [PRESCALE_WIDTH-1:0] prescale;
	} count_write_type;

endpackage

// ---- src/rtc_sync.sv ----
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module rtc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] first_stage;
	logic [WIDTH-1:0] next_first;
	logic [WIDTH-1:0] next_sync;

	if (WIDTH < 1) begin : g_bad_width
		$error("rtc_sync needs WIDTH of at least 1");
	end

	always_comb begin
		next_first = async_i;
		next_sync  = first_stage;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			first_stage <= '0;
			sync_o      <= '0;
		end else begin
			first_stage <= next_first;
			sync_o      <= next_sync;
		end
	end
endmodule
`default_nettype wire

// ---- src/reload_stage.sv ----
// one reloadable up-counting stage of the divider chain
`timescale 1ns/100ps
`default_nettype none
module reload_stage #(
	parameter int WIDTH = 10
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic             tick_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] load_value_i,
	input  wire logic [WIDTH-1:0] reload_value_i,
	output logic      [WIDTH-1:0] count_o,
	output logic                  carry_o
);
	logic [WIDTH-1:0] next_count;

	if (WIDTH < 2) begin : g_bad_width
		$error("reload_stage needs WIDTH of at least 2");
	end

	// carry is combinational so a whole cascade steps in one cycle
	always_comb begin
		carry_o = tick_i && (count_o == {WIDTH{1'b1}});
		next_count = count_o;
		if (load_i) begin
			next_count = load_value_i;
		end else if (carry_o) begin
			next_count = reload_value_i;
		end else if (tick_i) begin
			next_count = count_o + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_o <= '0;
		end else begin
			count_o <= next_count;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	chk_counts_up: assert property (
		tick_i && !load_i && !carry_o |=> count_o == $past(count_o) + 1'b1
	) else $error("stage did not step up by one on a tick");

	chk_holds_idle: assert property (
		!tick_i && !load_i |=> $stable(count_o)
	) else $error("stage moved without a tick");

	chk_wrap_reload: assert property (
		carry_o && !load_i |=> count_o == $past(reload_value_i)
	) else $error("stage did not reload its value on overflow");
endmodule
`default_nettype wire

// ---- sim/rtc_source_model.sv ----
// clock source model: internal tick pulses and an external clock pin
`timescale 1ns/100ps
`default_nettype none
module rtc_source_model (
	input  wire logic core_clk_i,
	output logic      int_tick_o,
	output logic      ext_clk_o
);
	initial begin
		int_tick_o = 1'b0;
		ext_clk_o  = 1'b0;
	end
	// back to back one-cycle pulses, launched on falling edges
	task automatic int_ticks(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk_i);
			int_tick_o = 1'b1;
		end
		@(negedge core_clk_i);
		int_tick_o = 1'b0;
	endtask
	// pin clock unrelated in phase, stands low between bursts
	task automatic ext_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			#13.7 ext_clk_o = 1'b1;
			#13.7 ext_clk_o = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ---- sim/rtc_divider_chain_tb.sv ----
// self-checking bench for the real time clock divider chain
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("[ERR] %0t got %h expected %h", $time, got, exp); \
	end \
end
module rtc_divider_chain_tb;
	import rtc_chain_pkg::*;
	logic                      clk;
	logic                      rst;
	chain_cfg_type             cfg;
	count_write_type           wr;
	logic [PRESCALE_WIDTH-1:0] pre_rld;
	logic [COUNT_WIDTH-1:0]    sub_rld;
	logic [COUNT_WIDTH-1:0]    alarm_val;
	logic                      alarm_on;
	logic [REQ_COUNT-1:0]      req_en;
	logic                      itick;
	logic                      eclk;
	logic [PRESCALE_WIDTH-1:0] pre;
	logic [WORD_WIDTH-1:0]     hi;
	logic [WORD_WIDTH-1:0]     lo;
	logic [TIMER48_WIDTH-1:0]  t48;
	logic [REQ_COUNT-1:0]      req;
	logic                      node;
	int                        n_fail = 0;
	int                        checks_done = 0;
	int                        cycles = 0;

	rtc_divider_chain u_dut (
		.core_clk_i              (clk),
		.reset_i                 (rst),
		.cfg_i                   (cfg),
		.int_tick_i              (itick),
		.ext_clk_i               (eclk),
		.prescale_reload_i       (pre_rld),
		.sub_reload_i            (sub_rld),
		.write_i                 (wr),
		.alarm_value_i           (alarm_val),
		.alarm_on_i              (alarm_on),
		.req_enable_i            (req_en),
		.prescale_reload_timer_o (pre),
		.count_high_word_o       (hi),
		.count_low_word_o        (lo),
		.timer48_o               (t48),
		.stage_req_o             (req),
		.node_req_o              (node)
	);
	rtc_source_model u_src (
		.core_clk_i (clk),
		.int_tick_o (itick),
		.ext_clk_o  (eclk)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// run needs under 2000 cycles; generous ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr_cnt(input count_write_type v);
		@(negedge clk);
		wr = v;
		@(negedge clk);
		wr = '0;
	endtask
	task automatic t_reset();
		rst = 1'b1;
		cyc(16);
		rst = 1'b0;
		`CHK({t48, hi, lo, pre}, 96'h0)
		`CHK({req, node}, 7'h00)
	endtask
	task automatic t_walk();
		req_en = '0;
		wr_cnt('{1'b1, 1'b0, 16'h0000, 1'b1, 16'hFFFF});
		u_src.int_ticks(1);
		`CHK({lo, pre}, {16'h0001, pre_rld})
		`CHK(node, 1'b0)
		pre_rld = 16'h3C5A;
		req_en = '1;
		wr_cnt('{1'b0, 1'b0, 16'h0000, 1'b1, 16'hFFFF});
		u_src.int_ticks(1);
		`CHK({lo, pre}, {16'h0002, pre_rld})
		`CHK({req, node}, 7'h03)
		cyc(1);
		`CHK({req, node}, 7'h00)
	endtask
	task automatic t_cascade();
		sub_rld = 32'h9ABC_DEF0;
		wr_cnt('{1'b1, 1'b0, 16'hFFFF, 1'b1, 16'hFFFF});
		wr_cnt('{1'b0, 1'b1, 16'hFFFF, 1'b0, 16'h0000});
		`CHK({hi, lo}, 32'hFFFF_FFFF)
		u_src.int_ticks(1);
		// all-ones overflow ripples through every stage in one cycle
		`CHK({hi, lo}, sub_rld)
		`CHK(t48, {sub_rld, pre_rld})
		`CHK({req, node}, 7'h3F)
	endtask
	task automatic t_div();
		int n [3] = '{15, 63, 256};
		for (int m = 0; m < 3; m++) begin
			cfg.div32_on = 1'b0;
			cfg.div8_on = 1'b0;
			wr_cnt('{1'b0, 1'b0, 16'h0000, 1'b1, 16'h0000});
			cfg.div32_on = (m != 0);
			cfg.div8_on = (m != 1);
			u_src.int_ticks(n[m]);
			`CHK(pre, 16'h0001)
		end
		cfg.div32_on = 1'b0;
		cfg.div8_on = 1'b0;
	endtask
	task automatic t_run_ext();
		cfg.run = 1'b0;
		wr_cnt('{1'b0, 1'b0, 16'h0000, 1'b1, 16'h0005});
		u_src.int_ticks(4);
		`CHK(pre, 16'h0005)
		cfg.run = 1'b1;
		cfg.ext_select = 1'b1;
		u_src.ext_pulses(3);
		cyc(6);
		`CHK(pre, 16'h0008)
		cfg.ext_select = 1'b0;
	endtask
	task automatic t_alarm();
		logic hit;
		hit = 1'b0;
		alarm_val = 32'h0000_0011;
		alarm_on = 1'b1;
		wr_cnt('{1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000});
		wr_cnt('{1'b1, 1'b0, 16'h0011, 1'b1, 16'h0000});
		// a written match must stay silent
		for (int i = 0; i < 4; i++) begin
			`CHK(req[REQ_ALARM], 1'b0)
			cyc(1);
		end
		wr_cnt('{1'b1, 1'b0, 16'h0010, 1'b1, 16'hFFFF});
		u_src.int_ticks(1);
		for (int i = 0; i < 4; i++) begin
			if (req[REQ_ALARM] === 1'b1) hit = node;
			cyc(1);
		end
		`CHK({hit, hi, lo}, 33'h1_0000_0011)
		alarm_on = 1'b0;
	endtask

	initial begin
		rst = 1'b1;
		cfg = '{run: 1'b1, ext_select: 1'b0, div32_on: 1'b0, div8_on: 1'b0};
		wr = '0;
		pre_rld = 16'hA5C3;
		sub_rld = 32'h1234_5678;
		alarm_val = '0;
		alarm_on = 1'b0;
		req_en = '1;
		t_reset();
		t_walk();
		t_cascade();
		t_div();
		t_run_ext();
		t_alarm();
		t_reset();
		conclude();
	end
endmodule
`default_nettype wire
